// File: design/shc_cfg.svh
`ifndef SHC_CFG_SVH
`define SHC_CFG_SVH

// Register map
`define SHC_ADDR_W        8
`define SHC_DATA_W        8
`define SHC_OFF_MODE      8'h5c
`define SHC_OFF_STATUS    8'h5d
`define SHC_MODE_RESET    8'h80

// Mode register fields
`define SHC_B_WD_EN       7
`define SHC_B_WD_PER_HI   6
`define SHC_B_WD_PER_LO   5
`define SHC_B_WARM        4
`define SHC_B_SEL_HI      3
`define SHC_B_SEL_LO      2
`define SHC_B_RST_LINK    1
`define SHC_B_DRIVE       0

// Standby select codes
`define SHC_SEL_RUN       2'h0
`define SHC_SEL_STOP      2'h1
`define SHC_SEL_IDLE      2'h2

// Warm-up, in oscillator periods
`define SHC_WARM_SHORT    65536
`define SHC_WARM_LONG     262144
`define SHC_CNT_W         18

// Port pins handled by the pull and drive logic
`define SHC_PINS          8
`define SHC_LVL_W         3

`endif

// File: design/shc_pkg.sv
`include "shc_cfg.svh"

package shc_pkg;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_RUN,
        ST_IDLE,
        ST_STOP,
        ST_WARM
    } shc_state_t;

    // Highest pending request as offered by the interrupt controller
    typedef enum logic [1:0] {
        SRC_OTHER,
        SRC_NMI,
        SRC_EXTERNAL_IRQ_PIN_ZERO
    } shc_src_t;

    typedef struct packed {
        logic                      req;
        logic [`SHC_LVL_W-1:0]     level;
        shc_src_t                  src;
    } shc_irq_t;

    typedef struct packed {
        logic [`SHC_PINS-1:0]      out_mode;
        logic [`SHC_PINS-1:0]      func_sel;
        logic [`SHC_PINS-1:0]      latch;
        logic [`SHC_PINS-1:0]      func_data;
        logic [`SHC_PINS-1:0]      has_pull;
        logic [`SHC_PINS-1:0]      out_only;
    } shc_pin_cfg_t;

    typedef struct packed {
        logic [`SHC_PINS-1:0]      oe_n;
        logic [`SHC_PINS-1:0]      in_en;
        logic [`SHC_PINS-1:0]      pull_en;
    } shc_pin_ctl_t;

    typedef struct packed {
        logic                      cpu_run;
        logic                      periph_run;
        logic                      osc_run;
        logic                      sys_run;
    } shc_clk_t;

endpackage

// File: design/shc_top.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "shc_cfg.svh"

// Behaviour
// - Halt instruction enters the standby mode picked by the mode field.
// - Mode field 00 RUN, 01 STOP, 10 IDLE, 11 don't care.
// - RUN stops only the CPU; oscillator and peripherals keep running.
// - IDLE keeps only the oscillator running; all other clocks stop.
// - STOP halts everything including the oscillator.
// - Non-reset STOP exit waits 2^16 or 2^18 periods, per warm bit.
// - IDLE and STOP end only by reset, NMI pin or external pin zero.
// - Mask not above request level: wake as allowed and start servicing.
// - Mask above level: only pin zero wakes; resume after halt, no service.
// - Drive bit set: outputs stay driven, input gates enabled in STOP.
// - Drive bit clear in STOP: no-pull pins float, gates off; pulls only.
// - Normally an input pin with pull enables it when latch holds 0.
// - In STOP each pull follows latch or output data captured at entry.
// - Output-only port pull: never in normal, in STOP when data is 0.
// - Function output pins follow function data; input functions the latch.
module shc_top #(
    parameter int WARM_SHORT_CYC = `SHC_WARM_SHORT,
    parameter int WARM_LONG_CYC  = `SHC_WARM_LONG
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       srst,
    // Register port
    input  wire logic [`SHC_ADDR_W-1:0]     reg_addr,
    input  wire logic [`SHC_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [`SHC_DATA_W-1:0]     reg_rdata,
    // CPU and interrupt controller
    input  wire logic                       halt_exec,
    input  wire logic [`SHC_LVL_W-1:0]      cpu_interrupt_mask_level,
    input  wire shc_pkg::shc_irq_t          irq,
    output logic                            wake_service,
    output logic                            wake_resume,
    output shc_pkg::shc_clk_t               clk_ctl,
    // Watchdog fields handed on
    output logic                            watchdog_enable_bit,
    output logic [1:0]                      watchdog_period,
    output logic                            watchdog_to_reset_link,
    // Port pins
    input  wire shc_pkg::shc_pin_cfg_t      pin_cfg,
    output shc_pkg::shc_pin_ctl_t           pin_ctl
);

    typedef struct packed {
        shc_pkg::shc_state_t                st;
        logic [`SHC_DATA_W-1:0]             mode;
        logic [`SHC_CNT_W-1:0]              warm_cnt;
        logic                               svc_pend;
        logic [`SHC_DATA_W-1:0]             rdata;
        logic                               wake_svc;
        logic                               wake_res;
        shc_pkg::shc_clk_t                  clk;
        logic [`SHC_PINS-1:0]               snap;
        shc_pkg::shc_pin_ctl_t              pins;
    } shc_regs_t;

    // Loaded with N-1: the count sits one cycle at zero before the exit
    localparam logic [`SHC_CNT_W-1:0] WARM_SHORT_LD =
        `SHC_CNT_W'(WARM_SHORT_CYC - 1);
    localparam logic [`SHC_CNT_W-1:0] WARM_LONG_LD =
        `SHC_CNT_W'(WARM_LONG_CYC - 1);

    shc_regs_t                       r;
    shc_regs_t                       next_r;

    // ------------------------------------------------------------------
    // Per-pin pull and drive
    // ------------------------------------------------------------------
    logic [`SHC_PINS-1:0]            pin_data;
    logic [`SHC_PINS-1:0]            norm_oe_n;
    logic [`SHC_PINS-1:0]            norm_pull;
    logic [`SHC_PINS-1:0]            stop_oe_n;
    logic [`SHC_PINS-1:0]            stop_in_en;
    logic [`SHC_PINS-1:0]            stop_pull;

    // Combinational per pin; the registered copy lives in r.pins
    genvar gi;
    generate
        for (gi = 0; gi < `SHC_PINS; gi++) begin : g_pin
            // Snapshot source: what the pin would show were it running
            // function data source
            assign pin_data[gi] = (pin_cfg.out_mode[gi] &&
                                   pin_cfg.func_sel[gi]) ?
                                  pin_cfg.func_data[gi] :
                                  pin_cfg.latch[gi];
            assign norm_oe_n[gi] = !(pin_cfg.out_mode[gi] ||
                                     pin_cfg.out_only[gi]);
            // Pull stays off on driven pins so it never fights the driver
            // latch steers pull
            assign norm_pull[gi] = pin_cfg.has_pull[gi] &&
                                   !pin_cfg.out_only[gi] &&
                                   !pin_cfg.out_mode[gi] &&
                                   !pin_cfg.latch[gi];
            // Floating pins get their gates shut to stop through current
            // keep driving
            assign stop_oe_n[gi] = r.mode[`SHC_B_DRIVE] ?
                                   norm_oe_n[gi] : 1'b1;
            assign stop_in_en[gi] = r.mode[`SHC_B_DRIVE];
            assign stop_pull[gi] = pin_cfg.has_pull[gi] && !r.snap[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Wake decode
    // ------------------------------------------------------------------
    logic                            lvl_ok;
    logic                            pin_src;
    logic                            wake_run;
    logic                            wake_deep;
    logic [1:0]                      sel;

    assign sel = r.mode[`SHC_B_SEL_HI:`SHC_B_SEL_LO];
    // Equal levels pass: the mask compare is inclusive
    // mask versus level
    assign lvl_ok = cpu_interrupt_mask_level <= irq.level;
    assign pin_src = irq.src == shc_pkg::SRC_NMI ||
                     irq.src == shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO;
    assign wake_run = irq.req &&
                      (lvl_ok || irq.src == shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO);
    // Deep modes also need an NMI or pin zero source
    assign wake_deep = irq.req && pin_src &&
                       (lvl_ok || irq.src == shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.wake_svc = 1'b0;
        next_r.wake_res = 1'b0;
        // Pulses and read data stand one cycle, then fall back to zero
        next_r.rdata = '0;

        if (reg_wr && reg_addr == `SHC_OFF_MODE) begin
            next_r.mode = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                `SHC_OFF_MODE: begin
                    next_r.rdata = r.mode;
                end
                // Status is read-only; a write to it is simply dropped
                `SHC_OFF_STATUS: begin
                    next_r.rdata = {4'h0, r.svc_pend, r.st};
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end

        case (r.st)
            shc_pkg::ST_ACTIVE: begin
                if (halt_exec) begin
                    case (sel)
                        `SHC_SEL_STOP: begin
                            next_r.st = shc_pkg::ST_STOP;
                            next_r.snap = pin_data;
                        end
                        `SHC_SEL_IDLE: begin
                            next_r.st = shc_pkg::ST_IDLE;
                        end
                        // Code 11 falls to RUN, the mildest mode
                        default: begin
                            next_r.st = shc_pkg::ST_RUN;
                        end
                    endcase
                end
            end
            shc_pkg::ST_RUN: begin
                if (wake_run) begin
                    next_r.st = shc_pkg::ST_ACTIVE;
                    next_r.wake_svc = lvl_ok;
                    next_r.wake_res = !lvl_ok;
                end
            end
            shc_pkg::ST_IDLE: begin
                if (wake_deep) begin
                    next_r.st = shc_pkg::ST_ACTIVE;
                    next_r.wake_svc = lvl_ok;
                    next_r.wake_res = !lvl_ok;
                end
            end
            shc_pkg::ST_STOP: begin
                if (wake_deep) begin
                    // A reset also ends STOP, but gets no warm-up count
                    // warm-up load
                    next_r.st = shc_pkg::ST_WARM;
                    next_r.svc_pend = lvl_ok;
                    next_r.warm_cnt = r.mode[`SHC_B_WARM] ?
                                      WARM_LONG_LD : WARM_SHORT_LD;
                end
            end
            shc_pkg::ST_WARM: begin
                // Wake choice was made on entry; irq is not looked at here
                if (r.warm_cnt == '0) begin
                    next_r.st = shc_pkg::ST_ACTIVE;
                    next_r.wake_svc = r.svc_pend;
                    next_r.wake_res = !r.svc_pend;
                    next_r.svc_pend = 1'b0;
                end else begin
                    next_r.warm_cnt = r.warm_cnt - 1'b1;
                end
            end
            default: begin
                next_r.st = shc_pkg::ST_ACTIVE;
            end
        endcase

        // Clocks follow the state being entered
        // so the clock change and the state change land on one edge
        case (next_r.st)
            shc_pkg::ST_RUN: begin
                next_r.clk = '{cpu_run: 1'b0, periph_run: 1'b1,
                               osc_run: 1'b1, sys_run: 1'b1};
            end
            shc_pkg::ST_IDLE: begin
                next_r.clk = '{cpu_run: 1'b0, periph_run: 1'b0,
                               osc_run: 1'b1, sys_run: 1'b0};
            end
            shc_pkg::ST_STOP: begin
                next_r.clk = '{cpu_run: 1'b0, periph_run: 1'b0,
                               osc_run: 1'b0, sys_run: 1'b0};
            end
            shc_pkg::ST_WARM: begin
                next_r.clk = '{cpu_run: 1'b0, periph_run: 1'b0,
                               osc_run: 1'b1, sys_run: 1'b0};
            end
            default: begin
                next_r.clk = '{cpu_run: 1'b1, periph_run: 1'b1,
                               osc_run: 1'b1, sys_run: 1'b1};
            end
        endcase

        // Pins keep their STOP state through the warm-up
        // so no pin glitches while the oscillator settles
        if (next_r.st == shc_pkg::ST_STOP ||
            next_r.st == shc_pkg::ST_WARM) begin
            next_r.pins.oe_n = stop_oe_n;
            next_r.pins.in_en = stop_in_en;
            next_r.pins.pull_en = stop_pull;
        end else begin
            next_r.pins.oe_n = norm_oe_n;
            next_r.pins.in_en = '1;
            next_r.pins.pull_en = norm_pull;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset; no field needs an asynchronous clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            r.st <= shc_pkg::ST_ACTIVE;
            r.mode <= `SHC_MODE_RESET;
            r.warm_cnt <= '0;
            r.svc_pend <= 1'b0;
            r.rdata <= '0;
            r.wake_svc <= 1'b0;
            r.wake_res <= 1'b0;
            r.clk <= '1;
            r.snap <= '0;
            // Pins come up undriven; normal values follow a cycle later
            r.pins.oe_n <= '1;
            r.pins.in_en <= '1;
            r.pins.pull_en <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = r.rdata;
    assign wake_service = r.wake_svc;
    assign wake_resume = r.wake_res;
    assign clk_ctl = r.clk;
    assign pin_ctl = r.pins;
    // Watchdog fields are only handed on; the timer lives elsewhere
    assign watchdog_enable_bit = r.mode[`SHC_B_WD_EN];
    assign watchdog_period = r.mode[`SHC_B_WD_PER_HI:`SHC_B_WD_PER_LO];
    assign watchdog_to_reset_link = r.mode[`SHC_B_RST_LINK];

endmodule // shc_top

// File: dv/shc_top_assertions.sv
`timescale 1ns/10ps
`include "shc_cfg.svh"
module shc_assert #(
    parameter int WARM_SHORT_CYC = 8,
    parameter int WARM_LONG_CYC  = 16
) (
    // Clock, reset, register port
    input wire logic                   mclk,
    input wire logic                   srst,
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // Standby side
    input wire logic                   halt_exec,
    input wire logic [2:0]             cpu_interrupt_mask_level,
    input wire shc_pkg::shc_irq_t      irq,
    input wire logic                   wake_service,
    input wire logic                   wake_resume,
    input wire shc_pkg::shc_clk_t      clk_ctl,
    // Pins
    input wire shc_pkg::shc_pin_cfg_t  pin_cfg,
    input wire shc_pkg::shc_pin_ctl_t  pin_ctl
);
// ----------
// Shadow state
// ----------
default clocking cb @(posedge mclk); endclocking
default disable iff (srst);
logic [7:0] mode;
logic       armed;
int         wcnt;
int         warm;
logic [3:0] halt_clk;
logic [7:0] n_oe;
logic [7:0] n_pull;
logic       wake;
assign wake = wake_service | wake_resume;
assign warm = mode[`SHC_B_WARM] ? WARM_LONG_CYC : WARM_SHORT_CYC;
assign halt_clk = (mode[3:2] == `SHC_SEL_STOP) ? 4'h0 :
                  (mode[3:2] == `SHC_SEL_IDLE) ? 4'h2 : 4'h7;
assign n_oe = ~(pin_cfg.out_mode | pin_cfg.out_only);
assign n_pull = pin_cfg.has_pull & ~pin_cfg.out_only & ~pin_cfg.out_mode
                & ~pin_cfg.latch;
// Counts cycles from an allowed wake edge in STOP to its pulse
always_ff @(posedge mclk) begin
    if (srst) begin
        mode <= 8'h80;
        armed <= 1'h0;
        wcnt <= 0;
    end else begin
        if (reg_wr && reg_addr == `SHC_OFF_MODE)
            mode <= reg_wdata;
        if (clk_ctl == 4'h0 && irq.req && irq.src != shc_pkg::SRC_OTHER) begin
            armed <= 1'h1;
            wcnt <= 1;
        end else begin
            wcnt <= wcnt + 1;
            if (wake)
                armed <= 1'h0;
        end
    end
end
// ----------
// Properties
// ----------
rd_mode_a: assert property (reg_rd && reg_addr == `SHC_OFF_MODE |=>
    reg_rdata == $past(mode)) else $error("mode read back wrong");
rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h0)
    else $error("read data outside its cycle");
halt_clk_a: assert property (halt_exec && clk_ctl == 4'hf |=>
    clk_ctl == $past(halt_clk)) else $error("standby clocks wrong");
wake_excl_a: assert property (!(wake_service && wake_resume))
    else $error("both wake pulses");
wake_clk_a: assert property (wake |-> clk_ctl == 4'hf)
    else $error("wake pulse with clocks stopped");
run_srv_a: assert property (clk_ctl == 4'h7 && irq.req &&
    irq.level >= cpu_interrupt_mask_level |=> wake_service)
    else $error("run wake not serviced");
run_res_a: assert property (clk_ctl == 4'h7 && irq.req &&
    irq.src == shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO && irq.level < cpu_interrupt_mask_level
    |=> wake_resume) else $error("run pin zero not resumed");
stop_hold_a: assert property (clk_ctl == 4'h0 &&
    !(irq.req && irq.src != shc_pkg::SRC_OTHER) |=> clk_ctl == 4'h0)
    else $error("stop left without allowed wake");
warm_len_a: assert property (armed && wake |-> wcnt == warm + 1)
    else $error("warm-up length wrong");
pin_norm_a: assert property (!$past(srst) && clk_ctl == 4'hf &&
    $past(clk_ctl) == 4'hf
    |-> pin_ctl.oe_n == $past(n_oe) && pin_ctl.in_en == 8'hff &&
    pin_ctl.pull_en == $past(n_pull)) else $error("normal pin control");
endmodule // shc_assert

// File: dv/shc_cpu_model.sv
`timescale 1ns/10ps
`include "shc_cfg.svh"
module shc_cpu_model (
    // Clock and wake answers
    input wire logic             mclk,
    input wire logic             wake_service,
    input wire logic             wake_resume,
    // Requests
    output logic                 halt_exec,
    output logic [2:0]           cpu_interrupt_mask_level,
    output shc_pkg::shc_irq_t    irq
);
initial begin
    halt_exec = 1'h0;
    cpu_interrupt_mask_level = 3'h0;
    irq = '0;
end
task automatic do_halt();
    @(posedge mclk);
    halt_exec <= 1'h1;
    @(posedge mclk);
    halt_exec <= 1'h0;
endtask
task automatic set_mask(input logic [2:0] m);
    @(posedge mclk);
    cpu_interrupt_mask_level <= m;
endtask
// Raise a request; n is cycles to the wake pulse, 0 if none came
task automatic post(input shc_pkg::shc_src_t s, input logic [2:0] lv,
                    input int lim, output int n, output logic srv);
    n = 0;
    @(posedge mclk);
    irq <= '{req: 1'h1, level: lv, src: s};
    repeat (lim) begin
        @(posedge mclk);
        #1;
        n++;
        if (wake_service || wake_resume)
            break;
    end
    srv = wake_service;
    if (!(wake_service || wake_resume))
        n = 0;
    // Released on the edge that samples the wake pulse
    @(posedge mclk);
    irq <= '0;
endtask
endmodule // shc_cpu_model

// File: dv/standby_halt_controller_bench.sv
`timescale 1ns/10ps
`include "shc_cfg.svh"
module standby_halt_controller_bench;
localparam int WS = 8;
localparam int WL = 16;
logic                  mclk, srst, reg_wr, reg_rd, halt_exec;
logic                  wake_service, wake_resume, wd_en, wd_link, srv;
logic [7:0]            reg_addr, reg_wdata, reg_rdata, got;
logic [2:0]            mask;
logic [1:0]            wd_per;
shc_pkg::shc_irq_t     irq;
shc_pkg::shc_clk_t     clk_ctl;
shc_pkg::shc_pin_cfg_t pin_cfg;
shc_pkg::shc_pin_ctl_t pin_ctl;
int                    n_mismatch, cmp_count, cyc, n;
shc_top #(.WARM_SHORT_CYC(WS), .WARM_LONG_CYC(WL)) u_dut (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_exec(halt_exec), .cpu_interrupt_mask_level(mask), .irq(irq),
    .wake_service(wake_service), .wake_resume(wake_resume),
    .clk_ctl(clk_ctl), .watchdog_enable_bit(wd_en),
    .watchdog_period(wd_per), .watchdog_to_reset_link(wd_link),
    .pin_cfg(pin_cfg), .pin_ctl(pin_ctl));
shc_cpu_model u_cpu (.mclk(mclk), .wake_service(wake_service),
    .wake_resume(wake_resume), .halt_exec(halt_exec),
    .cpu_interrupt_mask_level(mask), .irq(irq));
// ----------
// Helpers
// ----------
initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
end
always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
        n_mismatch++;
        tally_and_finish();
    end
end
task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 q = reg_rdata;
endtask
// reset held long enough to settle
task automatic do_reset();
    srst <= 1'h1;
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
endtask
task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
// ----------
// Scenarios
// ----------
task automatic s_regs();
    rd(`SHC_OFF_MODE, got);
    chk("mode_reset", got, 8'h80);
    wr(`SHC_OFF_MODE, 8'ha2);
    rd(`SHC_OFF_MODE, got);
    chk("mode_rw", got, 8'ha2);
    chk("wd_fields", {wd_en, wd_per, wd_link}, 4'hb);
    wr(8'h40, 8'h55);
    rd(8'h40, got);
    chk("unmapped", got, 8'h00);
    wr(`SHC_OFF_STATUS, 8'hff);
    rd(`SHC_OFF_STATUS, got);
    chk("status_active", got, 8'h00);
endtask
task automatic s_modes();
    logic [7:0] mt[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [3:0] ck[5] = '{4'h7, 4'h0, 4'h2, 4'h7, 4'h0};
    logic [7:0] st[5] = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h03};
    int         nx[5] = '{1, WS + 1, 1, 1, WL + 1};
    for (int i = 0; i < 5; i++) begin
        wr(`SHC_OFF_MODE, mt[i]);
        u_cpu.do_halt();
        #1 chk("standby_clk", clk_ctl, ck[i]);
        rd(`SHC_OFF_STATUS, got);
        chk("standby_state", got, st[i]);
        u_cpu.post(shc_pkg::SRC_NMI, 3'h7, 40, n, srv);
        chk("wake_cycles", n, nx[i]);
        chk("wake_srv", {srv, clk_ctl}, 5'h1f);
    end
endtask
task automatic s_mask();
    u_cpu.set_mask(3'h5);
    wr(`SHC_OFF_MODE, 8'h00);
    u_cpu.do_halt();
    u_cpu.post(shc_pkg::SRC_OTHER, 3'h3, 4, n, srv);
    chk("masked_other", n, 0);
    u_cpu.post(shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO, 3'h3, 4, n, srv);
    chk("pin0_resume", {n[3:0], srv}, 5'h02);
    u_cpu.set_mask(3'h0);
    wr(`SHC_OFF_MODE, 8'h08);
    u_cpu.do_halt();
    u_cpu.post(shc_pkg::SRC_OTHER, 3'h7, 4, n, srv);
    chk("idle_other", n, 0);
    u_cpu.post(shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO, 3'h2, 4, n, srv);
    chk("idle_pin0", {n[3:0], srv}, 5'h03);
endtask
task automatic s_pins();
    @(posedge mclk);
    pin_cfg <= '{8'h0f, 8'h05, 8'h33, 8'h0a, 8'hff, 8'h80};
    repeat (2) @(posedge mclk);
    #1 chk("norm_oe", pin_ctl.oe_n, 8'h70);
    chk("norm_pull", pin_ctl.pull_en, 8'h7f & 8'hf0 & ~8'h33);
    wr(`SHC_OFF_MODE, 8'h04);
    u_cpu.do_halt();
    @(posedge mclk);
    pin_cfg.latch <= 8'hcc;
    repeat (2) @(posedge mclk);
    #1 chk("float", {pin_ctl.oe_n, pin_ctl.in_en}, 16'hff00);
    // Snapshot 8'h32: function data on pins 0 and 2, latch elsewhere
    chk("stop_pull", pin_ctl.pull_en, 8'hcd);
    @(posedge mclk);
    do_reset();
    pin_cfg.latch <= 8'h33;
    #1 chk("reset_exit", clk_ctl, 4'hf);
    wr(`SHC_OFF_MODE, 8'h05);
    u_cpu.do_halt();
    repeat (2) @(posedge mclk);
    #1 chk("drive", {pin_ctl.oe_n, pin_ctl.in_en}, 16'h70ff);
    u_cpu.post(shc_pkg::SRC_EXTERNAL_IRQ_PIN_ZERO, 3'h0, 40, n, srv);
    chk("stop_pin0", n, WS + 1);
endtask
initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    pin_cfg = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    do_reset();
    s_regs();
    s_modes();
    s_mask();
    s_pins();
    tally_and_finish();
end
endmodule // standby_halt_controller_bench
bind shc_top shc_assert #(.WARM_SHORT_CYC(WARM_SHORT_CYC),
    .WARM_LONG_CYC(WARM_LONG_CYC)) u_chk (.mclk(mclk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
    .cpu_interrupt_mask_level(cpu_interrupt_mask_level), .irq(irq),
    .wake_service(wake_service), .wake_resume(wake_resume),
    .clk_ctl(clk_ctl), .pin_cfg(pin_cfg), .pin_ctl(pin_ctl));
